//--- cbid_regs.svh
/*
 Field positions, opcode patterns, reset values and fixed constants of the
 decrement-skip, branch and increment execute block.
 Assumes it is included by bare name from the package and the core.
*/
`ifndef CBID_REGS_SVH
`define CBID_REGS_SVH

`define CBID_INSTR_HI 13
`define CBID_OP6_LO 8
`define CBID_OP3_LO 11
`define CBID_DEST_BIT 7
`define CBID_FADDR_HI 6
`define CBID_K_HI 10
`define CBID_PC_HI 12
`define CBID_PC_UP_LO 11
`define CBID_LATCH_HI 4
`define CBID_LATCH_LO 3
`define CBID_OPC_DEC 6'h0b
`define CBID_OPC_INC 6'h0a
`define CBID_OPC_BR 3'h5
`define CBID_DEST_FILE 1'h1
`define CBID_PC_RST 13'h0000
`define CBID_PC_STEP 13'h0001
`define CBID_BYTE_ONE 8'h01
`define CBID_BYTE_ZERO 8'h00
`define CBID_W_RST 8'h00
`define CBID_INSTR_RST 14'h0000
`define CBID_FADDR_RST 7'h00

`endif

//--- cbid_pkg.sv
/*
 Types shared by the execute core: decoded operation and the core state record.
 Assumes cbid_regs.svh is on the include path.
*/
`include "cbid_regs.svh"

package cbid_pkg;
	typedef enum logic [1:0] {
		cbid_op_none,
		cbid_op_dec_skip,
		cbid_op_inc,
		cbid_op_branch
	} cbid_op_t;

	typedef struct packed {
		logic [13:0] instr_a;
		logic valid_a;
		logic [12:0] pc;
		logic [7:0] w;
		logic zero;
		logic wb_valid;
		logic wb_to_file;
		logic [6:0] wb_addr;
		logic [7:0] wb_data;
		logic discard;
	} cbid_state_t;

	function automatic cbid_op_t cbid_decode(input logic [13:0] instr);
		cbid_op_t op;
		op = cbid_op_none;
		if (instr[`CBID_INSTR_HI:`CBID_OP6_LO] == `CBID_OPC_DEC) begin
			op = cbid_op_dec_skip;
		end else if (instr[`CBID_INSTR_HI:`CBID_OP6_LO] == `CBID_OPC_INC) begin
			op = cbid_op_inc;
		end else if (instr[`CBID_INSTR_HI:`CBID_OP3_LO] == `CBID_OPC_BR) begin
			op = cbid_op_branch;
		end
		return op;
	endfunction
endpackage

//--- cbid_regfile.sv
/*
 File register store, 128 bytes, one write port and one read port.
 Assumes one clock; read data are registered and show the old byte when
 the same address is written in the same cycle.
*/
`timescale 1ns/1ps

module cbid_regfile (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [6:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:127];

	// No reset: contents are defined by software initialisation
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

//--- cbid_core.sv
/*
 Execute core for decrement-skip, unconditional branch and increment.
 Assumes instr_in is the fetched word offered each cycle on clk, and
 upc_latch holds the upper program counter latch, both from the same clock.
*/
// Functional notes
// - Pattern 00 1011 d fffffff writes file byte minus one to the destination, flags untouched.
// - A zero decrement result discards the instruction fetched behind it as a no-operation.
// - Destination bit 0 writes the accumulator, 1 writes the addressed file register.
// - Pattern 10 1 kkkkkkkkkkk loads the immediate into program counter bits 10 to 0.
// - The branch fills counter bits 12 and 11 from latch bits 4 and 3 and changes no flag.
// - A branch takes two cycles, the second discarding the instruction fetched behind it.
// - Pattern 00 1010 d fffffff writes file byte plus one to the destination and updates zero.
`timescale 1ns/1ps
`include "cbid_regs.svh"

module cbid_core (
	input wire logic clk,
	input wire logic reset,
	input wire logic [13:0] instr_in,
	input wire logic [7:0] upc_latch,
	input wire logic init_wr_en,
	input wire logic [6:0] init_wr_addr,
	input wire logic [7:0] init_wr_data,
	output logic [12:0] pc_out,
	output logic [7:0] w_out,
	output logic zero_flag,
	output logic wb_valid,
	output logic wb_to_file,
	output logic [6:0] wb_addr,
	output logic [7:0] wb_data,
	output logic discard
);
	cbid_pkg::cbid_state_t state_reg;
	cbid_pkg::cbid_state_t state_next;
	cbid_pkg::cbid_op_t exec_op;
	logic [7:0] file_rd_data;
	logic [7:0] operand;
	logic [7:0] result;
	logic mem_wr_en;
	logic [6:0] mem_wr_addr;
	logic [7:0] mem_wr_data;

	assign exec_op = state_reg.valid_a ? cbid_pkg::cbid_decode(state_reg.instr_a)
		: cbid_pkg::cbid_op_none;

	// Forward the byte written last cycle, the store still reads the old one
	assign operand = (state_reg.wb_valid && state_reg.wb_to_file
		&& state_reg.wb_addr == state_reg.instr_a[`CBID_FADDR_HI:0])
		? state_reg.wb_data : file_rd_data;

	always_comb begin
		state_next = state_reg;
		result = `CBID_BYTE_ZERO;
		state_next.instr_a = instr_in;
		state_next.valid_a = 1'b1;
		state_next.pc = state_reg.pc + `CBID_PC_STEP;
		state_next.wb_valid = 1'b0;
		state_next.discard = 1'b0;
		unique case (exec_op)
			cbid_pkg::cbid_op_dec_skip: begin
				result = operand - `CBID_BYTE_ONE;
				if (result == `CBID_BYTE_ZERO) begin
					state_next.valid_a = 1'b0;
					state_next.discard = 1'b1;
				end
			end
			cbid_pkg::cbid_op_inc: begin
				result = operand + `CBID_BYTE_ONE;
				state_next.zero = (result == `CBID_BYTE_ZERO);
			end
			cbid_pkg::cbid_op_branch: begin
				state_next.pc[`CBID_K_HI:0] = state_reg.instr_a[`CBID_K_HI:0];
				state_next.pc[`CBID_PC_HI:`CBID_PC_UP_LO] =
					upc_latch[`CBID_LATCH_HI:`CBID_LATCH_LO];
				state_next.valid_a = 1'b0;
				state_next.discard = 1'b1;
			end
			cbid_pkg::cbid_op_none: begin
			end
		endcase
		if (exec_op == cbid_pkg::cbid_op_dec_skip || exec_op == cbid_pkg::cbid_op_inc) begin
			state_next.wb_valid = 1'b1;
			state_next.wb_to_file = state_reg.instr_a[`CBID_DEST_BIT];
			state_next.wb_addr = state_reg.instr_a[`CBID_FADDR_HI:0];
			state_next.wb_data = result;
			if (state_reg.instr_a[`CBID_DEST_BIT] != `CBID_DEST_FILE) begin
				state_next.w = result;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg.instr_a <= `CBID_INSTR_RST;
			state_reg.valid_a <= 1'b0;
			state_reg.pc <= `CBID_PC_RST;
			state_reg.w <= `CBID_W_RST;
			state_reg.zero <= 1'b0;
			state_reg.wb_valid <= 1'b0;
			state_reg.wb_to_file <= 1'b0;
			state_reg.wb_addr <= `CBID_FADDR_RST;
			state_reg.wb_data <= `CBID_BYTE_ZERO;
			state_reg.discard <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Core write-back wins over initialisation writes in the same cycle
	assign mem_wr_en = (state_next.wb_valid && state_next.wb_to_file) || init_wr_en;
	assign mem_wr_addr = (state_next.wb_valid && state_next.wb_to_file)
		? state_next.wb_addr : init_wr_addr;
	assign mem_wr_data = (state_next.wb_valid && state_next.wb_to_file)
		? state_next.wb_data : init_wr_data;

	cbid_regfile u_regfile (
		.clk(clk),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data),
		.rd_addr(instr_in[`CBID_FADDR_HI:0]),
		.rd_data(file_rd_data)
	);

	assign pc_out = state_reg.pc;
	assign w_out = state_reg.w;
	assign zero_flag = state_reg.zero;
	assign wb_valid = state_reg.wb_valid;
	assign wb_to_file = state_reg.wb_to_file;
	assign wb_addr = state_reg.wb_addr;
	assign wb_data = state_reg.wb_data;
	assign discard = state_reg.discard;

	logic exec_dec;
	logic exec_inc;
	logic exec_br;
	assign exec_dec = (exec_op == cbid_pkg::cbid_op_dec_skip);
	assign exec_inc = (exec_op == cbid_pkg::cbid_op_inc);
	assign exec_br = (exec_op == cbid_pkg::cbid_op_branch);

	// The word after the bubble may be anything, so only the bubble itself is held quiet
	sequence s_bubble;
		discard && !state_reg.valid_a && !exec_dec && !exec_inc && !exec_br
			##1 !wb_valid && !discard;
	endsequence

	property p_dec_result;
		@(posedge clk) disable iff (reset)
		exec_dec |=> wb_valid && wb_data == 8'($past(operand) - `CBID_BYTE_ONE);
	endproperty
	a_dec_result: assert property (p_dec_result) else $error("decrement result wrong");

	property p_dec_flags;
		@(posedge clk) disable iff (reset)
		exec_dec |=> $stable(zero_flag);
	endproperty
	a_dec_flags: assert property (p_dec_flags) else $error("decrement changed zero");

	property p_skip;
		@(posedge clk) disable iff (reset)
		exec_dec && operand == `CBID_BYTE_ONE |=> s_bubble;
	endproperty
	a_skip: assert property (p_skip) else $error("skip did not discard");

	property p_no_skip;
		@(posedge clk) disable iff (reset)
		exec_dec && operand != `CBID_BYTE_ONE |=> !discard;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("spurious skip");

	property p_dest;
		@(posedge clk) disable iff (reset)
		(exec_dec || exec_inc) |=> wb_to_file == $past(state_reg.instr_a[`CBID_DEST_BIT])
			&& (wb_to_file || w_out == wb_data);
	endproperty
	a_dest: assert property (p_dest) else $error("destination wrong");

	property p_br_low;
		@(posedge clk) disable iff (reset)
		exec_br |=> pc_out[`CBID_K_HI:0] == $past(state_reg.instr_a[`CBID_K_HI:0]);
	endproperty
	a_br_low: assert property (p_br_low) else $error("branch low bits wrong");

	property p_br_high;
		@(posedge clk) disable iff (reset)
		exec_br |=> pc_out[`CBID_PC_HI:`CBID_PC_UP_LO]
			== $past(upc_latch[`CBID_LATCH_HI:`CBID_LATCH_LO]) && $stable(zero_flag);
	endproperty
	a_br_high: assert property (p_br_high) else $error("branch high bits wrong");

	property p_br_two;
		@(posedge clk) disable iff (reset)
		exec_br |=> s_bubble;
	endproperty
	a_br_two: assert property (p_br_two) else $error("branch not two cycles");

	property p_inc;
		@(posedge clk) disable iff (reset)
		exec_inc |=> wb_data == 8'($past(operand) + `CBID_BYTE_ONE)
			&& zero_flag == (wb_data == `CBID_BYTE_ZERO);
	endproperty
	a_inc: assert property (p_inc) else $error("increment or zero wrong");

	property p_hold_w;
		@(posedge clk) disable iff (reset)
		(exec_dec || exec_inc) && state_reg.instr_a[`CBID_DEST_BIT] == `CBID_DEST_FILE
			|=> $stable(w_out);
	endproperty
	a_hold_w: assert property (p_hold_w) else $error("accumulator written for file dest");

	property p_wb_addr;
		@(posedge clk) disable iff (reset)
		(exec_dec || exec_inc) |=> wb_addr == $past(state_reg.instr_a[`CBID_FADDR_HI:0]);
	endproperty
	a_wb_addr: assert property (p_wb_addr) else $error("write-back address wrong");

	property p_inc_once;
		@(posedge clk) disable iff (reset)
		exec_inc |=> !discard;
	endproperty
	a_inc_once: assert property (p_inc_once) else $error("increment discarded a word");

	property p_br_no_wb;
		@(posedge clk) disable iff (reset)
		exec_br |=> !wb_valid;
	endproperty
	a_br_no_wb: assert property (p_br_no_wb) else $error("branch wrote a result");
endmodule

//--- cbid_core_tb_top.sv
/*
 Self-checking bench for the decrement-skip, branch and increment core.
 Assumes cbid_core and cbid_regfile are compiled and cbid_regs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "cbid_regs.svh"
`define CBID_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module cbid_core_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [13:0] instr_in = 14'h0000;
	logic [7:0] upc_latch = 8'h00;
	logic init_wr_en = 1'b0;
	logic [6:0] init_wr_addr = 7'h00;
	logic [7:0] init_wr_data = 8'h00;
	logic [12:0] pc_out;
	logic [7:0] w_out;
	logic zero_flag;
	logic wb_valid;
	logic wb_to_file;
	logic [6:0] wb_addr;
	logic [7:0] wb_data;
	logic discard;
	logic [7:0] mem [128];
	logic [7:0] w_m = 8'h00;
	logic z_m = 1'b0;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	// Run needs about 1600 cycles; margin for a stalled pipeline
	localparam int max_cycles = 4000;

	always #12.5 clk = ~clk;

	cbid_core dut_u (.clk(clk), .reset(reset), .instr_in(instr_in), .upc_latch(upc_latch),
		.init_wr_en(init_wr_en), .init_wr_addr(init_wr_addr), .init_wr_data(init_wr_data),
		.pc_out(pc_out), .w_out(w_out), .zero_flag(zero_flag), .wb_valid(wb_valid),
		.wb_to_file(wb_to_file), .wb_addr(wb_addr), .wb_data(wb_data), .discard(discard));

	task automatic wrap_up();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == max_cycles) begin
			failures++;
			wrap_up();
		end
	end

	function automatic logic [7:0] alu(input logic [13:0] i, input logic [7:0] v);
		return (i[13:8] === `CBID_OPC_DEC) ? v - `CBID_BYTE_ONE : v + `CBID_BYTE_ONE;
	endfunction

	function automatic logic [13:0] make_op(input int kind, input logic [6:0] a, input logic d,
		input logic [10:0] k);
		if (kind == 0) begin
			return {`CBID_OPC_DEC, d, a};
		end else if (kind == 1) begin
			return {`CBID_OPC_INC, d, a};
		end
		return {`CBID_OPC_BR, k};
	endfunction

	// Idle cycle before the write keeps it clear of any core write-back
	task automatic poke(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		init_wr_en = 1'b1;
		init_wr_addr = a;
		init_wr_data = d;
		mem[a] = d;
		@(negedge clk);
		init_wr_en = 1'b0;
	endtask

	task automatic check_op(input logic [13:0] i, output logic skip);
		logic [7:0] r;
		r = alu(i, mem[i[6:0]]);
		skip = 1'b1;
		if (i[13:11] === `CBID_OPC_BR) begin
			`CBID_CHK(pc_out, {upc_latch[4:3], i[10:0]})
			`CBID_CHK(discard, 1'h1)
			`CBID_CHK(wb_valid, 1'h0)
			`CBID_CHK(zero_flag, z_m)
		end else begin
			`CBID_CHK(wb_valid, 1'h1)
			`CBID_CHK(wb_data, r)
			`CBID_CHK(wb_to_file, i[7])
			`CBID_CHK(wb_addr, i[6:0])
			if (i[7]) begin
				mem[i[6:0]] = r;
			end else begin
				w_m = r;
			end
			if (i[13:8] === `CBID_OPC_INC) begin
				z_m = (r === 8'h00);
			end
			skip = (i[13:8] === `CBID_OPC_DEC) && (r === 8'h00);
			`CBID_CHK(w_out, w_m)
			`CBID_CHK(zero_flag, z_m)
			`CBID_CHK(discard, skip)
		end
	endtask

	task automatic exec2(input logic [13:0] first, input logic [13:0] second);
		logic skip;
		logic dummy;
		@(negedge clk);
		instr_in = first;
		@(negedge clk);
		instr_in = second;
		// A word executes the cycle after it is taken; its results stand one edge later
		@(negedge clk);
		instr_in = `CBID_INSTR_RST;
		check_op(first, skip);
		@(negedge clk);
		if (skip) begin
			`CBID_CHK(wb_valid, 1'h0)
			`CBID_CHK(discard, 1'h0)
		end else begin
			check_op(second, dummy);
		end
	endtask

	initial begin
		logic [6:0] a;
		int kind;
		logic [13:0] fst;
		void'($urandom(46));
		repeat (4) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 128; i++) begin
			poke(i[6:0], 8'($urandom));
		end
		// Every fourth pass presets the operand so a first decrement hits zero and a first increment wraps
		for (int n = 0; n < 300; n++) begin
			a = 7'($urandom);
			kind = $urandom_range(2);
			if (n % 4 == 0) begin
				poke(a, (kind == 0) ? 8'h01 : 8'hff);
			end
			upc_latch = 8'($urandom);
			fst = make_op(kind, a, 1'($urandom), (n % 8 == 2) ? 11'h7ff : 11'($urandom));
			exec2(fst, make_op(1, ($urandom_range(1) == 1) ? a : 7'($urandom), 1'($urandom), 11'h000));
		end
		wrap_up();
	end
endmodule
